/* File: shared/memmap_regs.svh */
// Address map, configuration bit positions, fill values and timing counts
`ifndef MEMMAP_REGS_SVH
`define MEMMAP_REGS_SVH

// ----------------------------------------------------------------
// Address windows in the 64-Kbyte space
// ----------------------------------------------------------------
`define RAM_BASE 16'h0000
`define RAM_LAST 16'h00FF
`define EE_BASE 16'hB600
`define EE_LAST 16'hB7FF
`define BOOT_BASE 16'hBF40
`define BOOT_LAST 16'hBFFF
`define UROM_BASE 16'hE000
`define UROM_LAST 16'hFFFF

// ----------------------------------------------------------------
// Reset vectors and bootloader entry point
// ----------------------------------------------------------------
`define VEC_BOOT 16'hBFFE
`define VEC_USER 16'hFFFE
`define BOOT_ENTRY_HI 8'hBF
`define BOOT_ENTRY_LO 8'h40
`define USER_ENTRY_HI 8'hE0
`define USER_ENTRY_LO 8'h00

// ----------------------------------------------------------------
// Configuration byte layout (security bit is active low)
// ----------------------------------------------------------------
`define CFG_ROM_ENABLE_BIT 1
`define CFG_NO_SECURE_BIT 3

// ----------------------------------------------------------------
// Fill and erase values
// ----------------------------------------------------------------
`define EE_ERASED 8'hFF
`define RAM_CLEARED 8'h00
`define ROM_FILL 8'h01
`define BUS_IDLE_DATA 8'hFF

// ----------------------------------------------------------------
// Timing counts in mclk cycles
// ----------------------------------------------------------------
`define STRAP_SETTLE 2'h3
`define EXT_WAIT 3'h4

`endif

/* File: shared/memmap_pkg.sv */
// Types shared by the memory map decoder and the secure erase sequencer
package memmap_pkg;

    typedef enum logic [1:0] {
        MODE_BOOTSTRAP = 2'b00,
        MODE_TEST = 2'b01,
        MODE_SINGLE = 2'b10,
        MODE_EXPANDED = 2'b11
    } op_mode_e;

    typedef enum logic [2:0] {
        REGION_NONE = 3'b000,
        REGION_RAM = 3'b001,
        REGION_EE = 3'b010,
        REGION_BOOT = 3'b011,
        REGION_UROM = 3'b100,
        REGION_EXT = 3'b101
    } region_e;

    typedef enum logic [1:0] {
        CORE_STRAP = 2'b00,
        CORE_ERASE = 2'b01,
        CORE_RUN = 2'b10,
        CORE_EXT = 2'b11
    } core_state_e;

    typedef enum logic [2:0] {
        ER_IDLE = 3'b000,
        ER_WIPE = 3'b001,
        ER_CHECK = 3'b010,
        ER_CONFIG = 3'b011,
        ER_DONE = 3'b100
    } erase_state_e;

endpackage

/* File: design/secure_erase_seq.sv */
// Wipes EEPROM and RAM, verifies the wipe, then erases the configuration byte
`timescale 1ns/1ps
`include "memmap_regs.svh"

module secure_erase_seq #(
    parameter int EE_BYTES = 512,
    parameter int RAM_BYTES = 256,
    localparam int AW = $clog2(EE_BYTES)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Control
    input wire logic start,
    output logic done,
    // Array access
    output logic [AW-1:0] walk_addr,
    output logic ee_clear_we,
    output logic ram_clear_we,
    input wire logic [7:0] ee_rdata,
    input wire logic [7:0] ram_rdata,
    // Configuration byte erase request
    output logic cfg_erase
);

    initial begin
        if (EE_BYTES <= RAM_BYTES || (1 << AW) != EE_BYTES) begin
            $error("secure_erase_seq: EE_BYTES must be a power of two above RAM_BYTES");
        end
    end

    memmap_pkg::erase_state_e state_reg;
    logic [AW-1:0] walk_reg;
    logic fail_reg;
    logic in_ram;
    logic last;
    logic bad_now;

    assign in_ram = {1'b0, walk_reg} < (AW+1)'(RAM_BYTES);
    assign last = walk_reg == AW'(EE_BYTES - 1);
    assign bad_now = (ee_rdata != `EE_ERASED) || (in_ram && ram_rdata != `RAM_CLEARED);

    assign walk_addr = walk_reg;
    assign ee_clear_we = state_reg == memmap_pkg::ER_WIPE;
    assign ram_clear_we = state_reg == memmap_pkg::ER_WIPE && in_ram;
    assign cfg_erase = state_reg == memmap_pkg::ER_CONFIG;
    assign done = state_reg == memmap_pkg::ER_DONE;

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= memmap_pkg::ER_IDLE;
            walk_reg <= '0;
            fail_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                memmap_pkg::ER_IDLE: begin
                    if (start) begin
                        state_reg <= memmap_pkg::ER_WIPE;
                        walk_reg <= '0;
                    end
                end
                memmap_pkg::ER_WIPE: begin
                    walk_reg <= walk_reg + 1'b1;
                    if (last) begin
                        state_reg <= memmap_pkg::ER_CHECK;
                        fail_reg <= 1'b0;
                    end
                end
                memmap_pkg::ER_CHECK: begin
                    walk_reg <= walk_reg + 1'b1;
                    if (bad_now) begin
                        fail_reg <= 1'b1;
                    end
                    // Config byte is erased only after a clean verify pass
                    if (last) begin
                        state_reg <= (fail_reg || bad_now) ? memmap_pkg::ER_WIPE
                                                           : memmap_pkg::ER_CONFIG;
                    end
                end
                memmap_pkg::ER_CONFIG: begin
                    state_reg <= memmap_pkg::ER_DONE;
                end
                memmap_pkg::ER_DONE: begin
                    state_reg <= memmap_pkg::ER_DONE;
                end
                default: begin
                    state_reg <= memmap_pkg::ER_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: design/memory_map_core.sv */
// On-chip memory decoder with RAM, user ROM, bootloader ROM, EEPROM and security
//
// Overview of operation
// - 256-byte static RAM holds variables without refresh.
// - 8-Kbyte user ROM is read-only; writes are ignored.
// - 512-byte EEPROM is writable, erasable and keeps data.
// - Enable bit at 0 removes user ROM; fetches go external in expanded and test modes.
// - A separate 192-byte bootloader ROM exists beside user ROM.
// - In normal modes the bootloader ROM decodes no address.
// - In test mode bootloader ROM appears only after software enables it.
// - In bootstrap mode bootloader ROM sits at BF40 to BFFF from reset.
// - Bootstrap reset vector is read from BFFE and BFFF.
// - With security on, only single-chip or bootstrap modes are entered.
// - Single-chip reset vector comes from user ROM.
// - Single-chip mode never drives external address or data pins.
// - Secured bootstrap erases all EEPROM and RAM before download.
// - Configuration byte is erased only after erase is verified.
`timescale 1ns/1ps
`include "memmap_regs.svh"

module memory_map_core #(
    parameter int RAM_BYTES = 256,
    parameter int UROM_BYTES = 8192,
    parameter int BOOT_BYTES = 192,
    parameter int EE_BYTES = 512
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Mode strap pins
    input wire logic mode_a_pin,
    input wire logic mode_b_pin,
    // Nonvolatile configuration byte
    input wire logic [7:0] nv_config,
    output logic cfg_erase,
    // Test software request to map the bootloader ROM
    input wire logic boot_rom_enable_req,
    // CPU access port
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ready,
    output logic cpu_ack,
    output logic [7:0] cpu_rdata,
    // External memory bus
    output logic ext_bus_en,
    output logic [15:0] ext_addr,
    output logic ext_rd,
    output logic ext_wr,
    output logic [7:0] ext_data_out,
    output logic ext_data_oe_n,
    input wire logic [7:0] ext_data_in,
    // Status
    output logic [1:0] op_mode,
    output logic secure_active,
    output logic user_rom_enable_bit,
    output logic boot_rom_mapped,
    output logic erase_busy,
    output logic [15:0] reset_vector_addr
);

    localparam int EAW = $clog2(EE_BYTES);
    localparam int RAW = $clog2(RAM_BYTES);

    initial begin
        if (RAM_BYTES != 32'(`RAM_LAST - `RAM_BASE) + 1 ||
            UROM_BYTES != 32'(`UROM_LAST - `UROM_BASE) + 1 ||
            BOOT_BYTES != 32'(`BOOT_LAST - `BOOT_BASE) + 1 ||
            EE_BYTES != 32'(`EE_LAST - `EE_BASE) + 1) begin
            $error("memory_map_core: sizes must match the address windows");
        end
    end

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic in_window(input logic [15:0] a, input logic [15:0] lo,
                                       input logic [15:0] hi);
        in_window = a >= lo && a <= hi;
    endfunction

    function automatic memmap_pkg::region_e region_of(input logic [15:0] a,
                                                      input logic rom_on,
                                                      input logic boot_on,
                                                      input logic expanded);
        if (in_window(a, `RAM_BASE, `RAM_LAST)) begin
            region_of = memmap_pkg::REGION_RAM;
        end else if (in_window(a, `EE_BASE, `EE_LAST)) begin
            region_of = memmap_pkg::REGION_EE;
        end else if (boot_on && in_window(a, `BOOT_BASE, `BOOT_LAST)) begin
            region_of = memmap_pkg::REGION_BOOT;
        end else if (rom_on && in_window(a, `UROM_BASE, `UROM_LAST)) begin
            region_of = memmap_pkg::REGION_UROM;
        end else if (expanded) begin
            region_of = memmap_pkg::REGION_EXT;
        end else begin
            region_of = memmap_pkg::REGION_NONE;
        end
    endfunction

    // Mode from strap pins; security folds expanded modes onto single-chip ones
    function automatic memmap_pkg::op_mode_e resolve_mode(input logic ma, input logic mb,
                                                          input logic secure);
        if (secure) begin
            resolve_mode = mb ? memmap_pkg::MODE_SINGLE : memmap_pkg::MODE_BOOTSTRAP;
        end else begin
            resolve_mode = memmap_pkg::op_mode_e'({mb, ma});
        end
    endfunction

    // ----------------------------------------------------------------
    // Strap synchronisers and capture at reset release
    // ----------------------------------------------------------------
    logic ma_s1, ma_s2, ma_s3;
    logic mb_s1, mb_s2, mb_s3;
    logic [1:0] settle_reg;
    logic strap_take;
    memmap_pkg::core_state_e state_reg;
    memmap_pkg::op_mode_e mode_reg;
    logic rom_on_reg;
    logic secure_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {ma_s1, ma_s2, ma_s3} <= 3'h0;
            {mb_s1, mb_s2, mb_s3} <= 3'h0;
        end else begin
            {ma_s1, ma_s2, ma_s3} <= {mode_a_pin, ma_s1, ma_s2};
            {mb_s1, mb_s2, mb_s3} <= {mode_b_pin, mb_s1, mb_s2};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            settle_reg <= 2'h0;
        end else if (settle_reg != `STRAP_SETTLE) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    assign strap_take = state_reg == memmap_pkg::CORE_STRAP && settle_reg == `STRAP_SETTLE
                        && ma_s2 == ma_s3 && mb_s2 == mb_s3;

    // Configuration bits are frozen until the next reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= memmap_pkg::MODE_SINGLE;
            rom_on_reg <= 1'b0;
            secure_reg <= 1'b0;
        end else if (strap_take) begin
            rom_on_reg <= nv_config[`CFG_ROM_ENABLE_BIT];
            secure_reg <= !nv_config[`CFG_NO_SECURE_BIT];
            mode_reg <= resolve_mode(ma_s3, mb_s3, !nv_config[`CFG_NO_SECURE_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // Bootloader ROM visibility
    // ----------------------------------------------------------------
    logic boot_on_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            boot_on_reg <= 1'b0;
        end else if (strap_take) begin
            boot_on_reg <= resolve_mode(ma_s3, mb_s3, !nv_config[`CFG_NO_SECURE_BIT])
                           == memmap_pkg::MODE_BOOTSTRAP;
        end else if (mode_reg == memmap_pkg::MODE_TEST && boot_rom_enable_req) begin
            boot_on_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Secure erase sequencer
    // ----------------------------------------------------------------
    logic erase_start;
    logic erase_done;
    logic [EAW-1:0] walk_addr;
    logic ee_clear_we;
    logic ram_clear_we;
    logic [7:0] ee_walk_data;
    logic [7:0] ram_walk_data;

    assign erase_start = state_reg == memmap_pkg::CORE_ERASE;

    secure_erase_seq #(
        .EE_BYTES(EE_BYTES),
        .RAM_BYTES(RAM_BYTES)
    ) u_erase (
        .mclk(mclk),
        .resetn(resetn),
        .start(erase_start),
        .done(erase_done),
        .walk_addr(walk_addr),
        .ee_clear_we(ee_clear_we),
        .ram_clear_we(ram_clear_we),
        .ee_rdata(ee_walk_data),
        .ram_rdata(ram_walk_data),
        .cfg_erase(cfg_erase)
    );

    // ----------------------------------------------------------------
    // Access control
    // ----------------------------------------------------------------
    logic expanded;
    logic take;
    memmap_pkg::region_e region;
    logic [2:0] wait_reg;
    logic rd_pend_reg;
    logic [7:0] din_s1, din_s2, din_s3;

    assign expanded = mode_reg == memmap_pkg::MODE_EXPANDED || mode_reg == memmap_pkg::MODE_TEST;
    assign region = region_of(cpu_addr, rom_on_reg, boot_on_reg, expanded);
    assign cpu_ready = state_reg == memmap_pkg::CORE_RUN;
    assign take = cpu_ready && cpu_req;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= memmap_pkg::CORE_STRAP;
        end else begin
            unique case (state_reg)
                memmap_pkg::CORE_STRAP: begin
                    if (strap_take) begin
                        state_reg <= (!nv_config[`CFG_NO_SECURE_BIT] &&
                                      resolve_mode(ma_s3, mb_s3, 1'b1) ==
                                      memmap_pkg::MODE_BOOTSTRAP)
                                     ? memmap_pkg::CORE_ERASE : memmap_pkg::CORE_RUN;
                    end
                end
                memmap_pkg::CORE_ERASE: begin
                    if (erase_done) begin
                        state_reg <= memmap_pkg::CORE_RUN;
                    end
                end
                memmap_pkg::CORE_RUN: begin
                    if (take && region == memmap_pkg::REGION_EXT) begin
                        state_reg <= memmap_pkg::CORE_EXT;
                    end
                end
                memmap_pkg::CORE_EXT: begin
                    if (wait_reg == `EXT_WAIT && (!rd_pend_reg || din_s2 == din_s3)) begin
                        state_reg <= memmap_pkg::CORE_RUN;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // External bus, quiet outside expanded modes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {din_s1, din_s2, din_s3} <= 24'h0;
        end else begin
            {din_s1, din_s2, din_s3} <= {ext_data_in, din_s1, din_s2};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_reg <= 3'h0;
            rd_pend_reg <= 1'b0;
            ext_addr <= 16'h0000;
            ext_rd <= 1'b0;
            ext_wr <= 1'b0;
            ext_data_out <= 8'h00;
            ext_data_oe_n <= 1'b1;
        end else if (take && region == memmap_pkg::REGION_EXT) begin
            wait_reg <= 3'h1;
            rd_pend_reg <= !cpu_we;
            ext_addr <= cpu_addr;
            ext_rd <= !cpu_we;
            ext_wr <= cpu_we;
            ext_data_out <= cpu_we ? cpu_wdata : 8'h00;
            ext_data_oe_n <= !cpu_we;
        end else if (state_reg == memmap_pkg::CORE_EXT && wait_reg != `EXT_WAIT) begin
            wait_reg <= wait_reg + 3'h1;
        end else if (state_reg == memmap_pkg::CORE_EXT && state_reg != memmap_pkg::CORE_RUN &&
                     (!rd_pend_reg || din_s2 == din_s3)) begin
            wait_reg <= 3'h0;
            rd_pend_reg <= 1'b0;
            ext_rd <= 1'b0;
            ext_wr <= 1'b0;
            ext_data_oe_n <= 1'b1;
        end
    end

    // Pins only move in expanded modes; single-chip keeps them idle
    assign ext_bus_en = expanded;

    // ----------------------------------------------------------------
    // Memory arrays
    // ----------------------------------------------------------------
    logic [7:0] ram_mem [RAM_BYTES];
    logic [7:0] ee_mem [EE_BYTES];
    logic [RAW-1:0] ram_off;
    logic [EAW-1:0] ee_off;

    assign ram_off = cpu_addr[RAW-1:0];
    assign ee_off = EAW'(cpu_addr - `EE_BASE);
    assign ee_walk_data = ee_mem[walk_addr];
    assign ram_walk_data = ram_mem[walk_addr[RAW-1:0]];

    // Static RAM, no refresh needed
    always_ff @(posedge mclk) begin
        if (ram_clear_we) begin
            ram_mem[walk_addr[RAW-1:0]] <= `RAM_CLEARED;
        end else if (take && cpu_we && region == memmap_pkg::REGION_RAM) begin
            ram_mem[ram_off] <= cpu_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (ee_clear_we) begin
            ee_mem[walk_addr] <= `EE_ERASED;
        end else if (take && cpu_we && region == memmap_pkg::REGION_EE) begin
            ee_mem[ee_off] <= cpu_wdata;
        end
    end

    // Mask ROM images: filler plus the reset vector bytes
    function automatic logic [7:0] urom_byte(input logic [15:0] a);
        if (a == `VEC_USER) begin
            urom_byte = `USER_ENTRY_HI;
        end else if (a == `VEC_USER + 16'h0001) begin
            urom_byte = `USER_ENTRY_LO;
        end else begin
            urom_byte = `ROM_FILL;
        end
    endfunction

    function automatic logic [7:0] boot_byte(input logic [15:0] a);
        if (a == `VEC_BOOT) begin
            boot_byte = `BOOT_ENTRY_HI;
        end else if (a == `VEC_BOOT + 16'h0001) begin
            boot_byte = `BOOT_ENTRY_LO;
        end else begin
            boot_byte = `ROM_FILL;
        end
    endfunction

    // ----------------------------------------------------------------
    // Read answer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cpu_ack <= 1'b0;
            cpu_rdata <= 8'h00;
        end else begin
            cpu_ack <= (take && region != memmap_pkg::REGION_EXT) ||
                       (state_reg == memmap_pkg::CORE_EXT && wait_reg == `EXT_WAIT &&
                        (!rd_pend_reg || din_s2 == din_s3));
            if (take && !cpu_we) begin
                unique case (region)
                    memmap_pkg::REGION_RAM: cpu_rdata <= ram_mem[ram_off];
                    memmap_pkg::REGION_EE: cpu_rdata <= ee_mem[ee_off];
                    memmap_pkg::REGION_BOOT: cpu_rdata <= boot_byte(cpu_addr);
                    memmap_pkg::REGION_UROM: cpu_rdata <= urom_byte(cpu_addr);
                    memmap_pkg::REGION_EXT: cpu_rdata <= cpu_rdata;
                    memmap_pkg::REGION_NONE: cpu_rdata <= `BUS_IDLE_DATA;
                endcase
            end else if (state_reg == memmap_pkg::CORE_EXT && rd_pend_reg &&
                         wait_reg == `EXT_WAIT && din_s2 == din_s3) begin
                cpu_rdata <= din_s3;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    assign op_mode = mode_reg;
    assign secure_active = secure_reg;
    assign user_rom_enable_bit = rom_on_reg;
    assign boot_rom_mapped = boot_on_reg;
    assign erase_busy = state_reg == memmap_pkg::CORE_ERASE;
    assign reset_vector_addr = mode_reg == memmap_pkg::MODE_BOOTSTRAP
                               ? `VEC_BOOT : `VEC_USER;

endmodule

/* File: dv/memmap_assertions.sv */
// Concurrent checks on the memory map core ports
`timescale 1ns/1ps
module memmap_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Watched ports
    input wire logic cpu_req,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_ready,
    input wire logic cpu_ack,
    input wire logic cfg_erase,
    input wire logic ext_rd,
    input wire logic ext_wr,
    input wire logic [1:0] op_mode,
    input wire logic secure_active,
    input wire logic user_rom_enable_bit,
    input wire logic boot_rom_mapped,
    input wire logic [15:0] reset_vector_addr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_no_ext_bus: assert property (op_mode == 2'h2 |-> !ext_rd && !ext_wr)
        else $error("external strobe in single-chip mode");
    a_boot_vector: assert property (op_mode == 2'h0 |-> reset_vector_addr == 16'hBFFE)
        else $error("bootstrap vector address wrong");
    a_user_vector: assert property (op_mode != 2'h0 |-> reset_vector_addr == 16'hFFFE)
        else $error("user vector address wrong");
    a_secure_modes: assert property (secure_active |-> !op_mode[0])
        else $error("secured part in a refused mode");
    a_cfg_held: assert property (cpu_ready |=>
        $stable({user_rom_enable_bit, secure_active})) else $error("config bits changed");
    a_normal_no_boot: assert property (op_mode[1] |-> !boot_rom_mapped)
        else $error("boot ROM mapped in normal mode");
    a_boot_mapped: assert property (cpu_ready && op_mode == 2'h0 |-> boot_rom_mapped)
        else $error("boot ROM absent in bootstrap mode");
    a_ram_answer: assert property (cpu_req && cpu_ready && cpu_addr[15:8] == 8'h00 |=>
        cpu_ack) else $error("RAM access not answered");
    a_cfg_pulse: assert property (cfg_erase |=> !cfg_erase ##[0:8] cpu_ready)
        else $error("config erase pulse wrong");
    c_erase: cover property (cfg_erase);
    c_ext_read: cover property (ext_rd);
    c_boot_read: cover property (cpu_ack && boot_rom_mapped);
endmodule
bind memory_map_core memmap_assertions i_memmap_assertions (.mclk, .resetn, .cpu_req,
    .cpu_addr, .cpu_ready, .cpu_ack, .cfg_erase, .ext_rd, .ext_wr, .op_mode, .secure_active,
    .user_rom_enable_bit, .boot_rom_mapped, .reset_vector_addr);

/* File: dv/cpu_model.sv */
// CPU core model issuing byte accesses
`timescale 1ns/1ps
module cpu_model (
    // Clock
    input wire logic mclk,
    // Access port
    output logic cpu_req,
    output logic cpu_we,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    input wire logic cpu_ready,
    input wire logic cpu_ack,
    input wire logic [7:0] cpu_rdata
);
    initial begin
        cpu_req = 1'b0;
        cpu_we = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
    end
    // Held until taken; idle address and data are inverted so nothing stale lingers
    task automatic access(input logic we, input logic [15:0] a, input logic [7:0] wd,
        output logic [7:0] rd);
        int n;
        rd = 8'hXX;
        @(posedge mclk);
        #1;
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_addr = a;
        cpu_wdata = wd;
        @(posedge mclk);
        for (n = 0; n < 3000 && cpu_ready !== 1'b1; n++) @(posedge mclk);
        #1;
        cpu_req = 1'b0;
        cpu_addr = ~a;
        cpu_wdata = ~wd;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (cpu_ack === 1'b1) begin
                rd = cpu_rdata;
                break;
            end
        end
        #1;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the memory map core
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic mode_a_pin = 1'b0;
    logic mode_b_pin = 1'b1;
    logic [7:0] nv_config = 8'h0A;
    logic boot_rom_enable_req = 1'b0;
    logic [7:0] ext_data_in = 8'h3C;
    logic cpu_req, cpu_we, cpu_ready, cpu_ack, cfg_erase, secure_active;
    logic user_rom_enable_bit, boot_rom_mapped, ext_bus_en;
    logic [15:0] cpu_addr, reset_vector_addr, ext_addr;
    logic [7:0] cpu_wdata, cpu_rdata, v;
    logic [1:0] op_mode;
    int err_count = 0, checks = 0;
    int cyc = 0, n_cfg = 0;
    always #20 mclk = ~mclk;
    memory_map_core i_memory_map_core (.mclk, .resetn, .mode_a_pin, .mode_b_pin, .nv_config,
        .cfg_erase, .boot_rom_enable_req, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ready,
        .cpu_ack, .cpu_rdata, .ext_bus_en, .ext_addr, .ext_rd(), .ext_wr(), .ext_data_out(),
        .ext_data_oe_n(), .ext_data_in, .op_mode, .secure_active, .user_rom_enable_bit,
        .boot_rom_mapped, .erase_busy(), .reset_vector_addr);
    cpu_model i_cpu_model (.mclk, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ready,
        .cpu_ack, .cpu_rdata);
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cfg_erase === 1'b1) n_cfg <= n_cfg + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        i_cpu_model.access(1'b0, a, 8'h00, v);
        chk("read data", {8'h00, e}, {8'h00, v});
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        i_cpu_model.access(1'b1, a, d, v);
    endtask
    task start(input logic [1:0] m, input logic [7:0] c);
        @(posedge mclk);
        #1;
        resetn = 1'b0;
        {mode_b_pin, mode_a_pin} = m;
        nv_config = c;
        repeat (6) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (3000) if (cpu_ready !== 1'b1) @(posedge mclk);
        #1;
    endtask
    task t_single;
        start(2'h2, 8'h0A);
        chk("vector", 16'hFFFE, reset_vector_addr);
        chk("bus enable", 16'h0000, {15'h0000, ext_bus_en});
        rd(16'hFFFE, 8'hE0);
        rd(16'hFFFF, 8'h00);
        wr(16'hE000, 8'h5A);
        rd(16'hE000, 8'h01);
        rd(16'hBF40, 8'hFF);
        wr(16'h0010, 8'h5A);
        wr(16'h00FF, 8'hC3);
        rd(16'h0010, 8'h5A);
        rd(16'h00FF, 8'hC3);
        wr(16'hB7FF, 8'h96);
        rd(16'hB7FF, 8'h96);
        nv_config = 8'h00;
        rd(16'hE001, 8'h01);
        chk("rom enable", 16'h0001, {15'h0000, user_rom_enable_bit});
        $display("single-chip test done");
    endtask
    task t_boot;
        start(2'h0, 8'h0A);
        chk("vector", 16'hBFFE, reset_vector_addr);
        rd(16'hBFFE, 8'hBF);
        rd(16'hBFFF, 8'h40);
        rd(16'h0010, 8'h5A);
        chk("erase pulses", 16'h0000, n_cfg[15:0]);
        $display("bootstrap test done");
    endtask
    task t_romoff;
        start(2'h3, 8'h08);
        rd(16'hE000, 8'h3C);
        rd(16'hBF40, 8'h3C);
        chk("ext address", 16'hBF40, ext_addr);
        chk("rom enable", 16'h0000, {15'h0000, user_rom_enable_bit});
        $display("rom disabled test done");
    endtask
    task t_test;
        start(2'h1, 8'h0A);
        rd(16'hBFFE, 8'h3C);
        boot_rom_enable_req = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        rd(16'hBFFE, 8'hBF);
        boot_rom_enable_req = 1'b0;
        $display("test mode test done");
    endtask
    task t_secure;
        n_cfg = 0;
        start(2'h0, 8'h02);
        chk("erase pulses", 16'h0001, n_cfg[15:0]);
        rd(16'hB7FF, 8'hFF);
        rd(16'h0010, 8'h00);
        start(2'h1, 8'h02);
        chk("mode", 16'h0000, {14'h0000, op_mode});
        start(2'h3, 8'h02);
        chk("mode", 16'h0002, {14'h0000, op_mode});
        $display("security test done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        t_single();
        t_boot();
        t_romoff();
        t_test();
        t_secure();
        end_of_test();
    end
endmodule
